// >>> inc/tatc_defs.svh
// Register offsets, field positions and reset values of the timed converter trigger control
`ifndef TATC_DEFS_SVH
`define TATC_DEFS_SVH
// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define TATC_ADR_SC1A   8'h00
`define TATC_ADR_SC1B   8'h04
`define TATC_ADR_CFG2   8'h08
`define TATC_ADR_RA     8'h0C
`define TATC_ADR_RB     8'h10
`define TATC_ADR_SC2    8'h14
`define TATC_ADR_SC3    8'h18
`define TATC_ADR_TRG    8'h1C
`define TATC_ADR_TCSR   8'h20
`define TATC_ADR_TPSR   8'h24
`define TATC_ADR_TCMR   8'h28
`define TATC_ADR_TCNR   8'h2C
`define TATC_ADR_IST    8'h30
`define TATC_ADR_IMSK   8'h34
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TATC_SC1_AIEN   6
`define TATC_SC1_CONVERSION_COMPLETE_FLAG   7
`define TATC_CFG2_BANK  4
`define TATC_SC2_HWTRG  6
`define TATC_SC3_CAL    7
`define TATC_SC3_HARDWARE_AVERAGE_ENABLE   2
`define TATC_TRG_ALT    0
`define TATC_TRG_PRE    1
`define TATC_TCSR_EN    0
`define TATC_TCSR_MODE  1
`define TATC_TCSR_FREE  2
`define TATC_TCSR_PIN   4
`define TATC_TCSR_FLAG  7
`define TATC_TPSR_BYP   2
`define TATC_TPSR_PRE   3
`define TATC_IRQ_A      0
`define TATC_IRQ_B      1
`define TATC_IRQ_T      2
`define TATC_IRQ_C      3
// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define TATC_CH_OFF     5'h1F
`define TATC_BANK_LO    5'h04
`define TATC_BANK_HI    5'h07
`define TATC_AVG_BASE   3'h2
`define TATC_CAL_AVGS   2'h3
`define TATC_CAL_SHIFT  3'h5
`define TATC_CMR_RST    16'h0000
`endif

// >>> inc/tatc_pkg.sv
// Types shared by the timed converter trigger control
`default_nettype none
package tatc_pkg;
  typedef enum logic [1:0] {CS_IDLE, CS_RUN, CS_WAIT} tatc_conv_state_type;
endpackage : tatc_pkg
`default_nettype wire

// >>> sim/tatc_conv_model.sv
// Behavioural converter that answers every start with a result tagged by channel and pin
`default_nettype none
module tatc_conv_model #(
  parameter int DELAY = 6
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [4:0]  channel_i,
  input  wire logic        bank_b_i,
  output logic             done_o,
  output logic [15:0]      result_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_reg;
  // Result bus toggles outside the done cycle so a stale sample never matches
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 0;
      done_o <= 1'b0;
      result_o <= 16'hFFFF;
    end else begin
      done_o <= 1'b0;
      result_o <= ~result_o;
      if (start_i) cnt_reg <= DELAY;
      else if (cnt_reg != 0) cnt_reg <= cnt_reg - 1;
      if (cnt_reg == 1) begin
        done_o <= 1'b1;
        result_o <= {10'h155, bank_b_i, channel_i};
      end
    end
  end
endmodule : tatc_conv_model
`default_nettype wire

// >>> sim/timed_adc_trigger_control_tb.sv
// Self-checking bench of the timed converter trigger control
`default_nettype none
`include "tatc_defs.svh"
module timed_adc_trigger_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, irc = 0, pz = 0, po = 0, done, ack, irq, start, bank;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, rdo, q;
  logic [3:0] sel = 0, pins = 0;
  logic [4:0] ch;
  logic [15:0] res;
  int num_errors = 0, samples_checked = 0, starts = 0, cyc_n = 0, s0;
  logic [7:0] ra [4] = '{8'h08, 8'h1C, 8'h28, 8'h3C};
  logic [31:0] rd [4] = '{32'h10, 32'h3, 32'h1234, 32'h0};
  logic [4:0] cl [4] = '{5'h03, 5'h04, 5'h07, 5'h04};
  logic bl [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  tatc_top DUT (.core_clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdo), .wb_ack_o(ack), .irq_o(irq), .pwm_timer_channel_zero_i(pz),
    .pwm_timer_channel_one_i(po), .irc_clk_i(irc), .lpo_clk_i(irc), .rtc_clk_i(irc), .osc_clk_i(irc),
    .comparator_output_i(pins[0]), .pulse_input_alt_one_i(pins[1]), .pulse_input_alt_two_i(pins[2]),
    .pulse_input_alt_three_i(pins[3]), .conv_start_o(start), .conv_channel_o(ch), .conv_bank_b_o(bank),
    .conv_done_i(done), .conv_result_i(res));
  tatc_conv_model CONV (.core_clk_i(clk), .rst_i(rst), .start_i(start), .channel_i(ch), .bank_b_i(bank),
    .done_o(done), .result_o(res));
  initial forever #25 clk = ~clk;
  initial forever #170 irc = ~irc;
  always @(posedge clk) begin
    starts <= starts + int'(start === 1'b1);
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // ----------------------------------------
  // Classic single-cycle bus access
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdo;
    cyc <= 0;
    stb <= 0;
  endtask : wb
  task automatic wait_irq();
    for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk);
    check("irq", irq, 1'b1);
  endtask : wait_irq
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    check("reset channel", ch, 5'h1F);
    check("reset irq", irq, 1'b0);
    rst <= 0;
    wb(0, `TATC_ADR_TRG, 0);
    check("trigger reset", q, 32'h0);
    wb(0, `TATC_ADR_SC1A, 0);
    check("channel reset", q, 32'h1F);
    for (int i = 0; i < 4; i++) begin
      wb(1, ra[i], rd[i] | 32'h20000);
      wb(0, ra[i], 0);
      check("readback", q, rd[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wb(1, `TATC_ADR_CFG2, 32'(bl[i]) << 4);
      wb(1, `TATC_ADR_IMSK, 32'h1);
      wb(1, `TATC_ADR_SC1A, 32'h40 | 32'(cl[i]));
      wait_irq();
      check("bank", bank, bl[i] && cl[i] >= 4 && cl[i] <= 7);
      wb(0, `TATC_ADR_RA, 0);
      check("result", q, {16'h0, 10'h155, bl[i] && cl[i] >= 4 && cl[i] <= 7, cl[i]});
      repeat (3) @(posedge clk);
      check("irq cleared", irq, 1'b0);
      wb(0, `TATC_ADR_SC1A, 0);
      check("flag cleared", q, 32'h40 | 32'(cl[i]));
    end
    s0 = starts;
    wb(1, `TATC_ADR_SC1A, 32'h1F);
    repeat (30) @(posedge clk);
    check("no start", starts, s0);
    // Calibration runs a 32-sample set on slot A and rewrites the averaging setup
    wb(1, `TATC_ADR_IMSK, 32'h8);
    wb(1, `TATC_ADR_SC3, 32'h80);
    wait_irq();
    wb(0, `TATC_ADR_SC3, 0);
    check("calibration config", q, 32'h7);
    wb(0, `TATC_ADR_RA, 0);
    check("averaged result", q, 32'h555F);
    s0 = starts;
    wb(1, `TATC_ADR_TPSR, 32'h4);
    wb(1, `TATC_ADR_TCMR, 32'h3);
    wb(1, `TATC_ADR_TRG, 32'h1);
    wb(1, `TATC_ADR_SC2, 32'h40);
    wb(1, `TATC_ADR_SC1A, 32'h2);
    wb(1, `TATC_ADR_IMSK, 32'h4);
    wb(1, `TATC_ADR_TCSR, 32'h1);
    wait_irq();
    wb(0, `TATC_ADR_IST, 0);
    check("timer status", q & 32'h4, 32'h4);
    for (int i = 0; i < 6; i++) begin
      wb(0, `TATC_ADR_TCNR, 0);
      check("count bound", q <= 32'h3, 1'b1);
    end
    repeat (200) @(posedge clk);
    check("timer start", starts > s0, 1'b1);
    wb(1, `TATC_ADR_TCSR, 32'h0);
    wb(1, `TATC_ADR_TCMR, 32'hFF);
    wb(1, `TATC_ADR_TPSR, 32'h0);
    wb(1, `TATC_ADR_TCSR, 32'h13);
    repeat (4) begin
      pins <= 4'h2;
      repeat (6) @(posedge clk);
      pins <= 4'h0;
      repeat (6) @(posedge clk);
    end
    wb(0, `TATC_ADR_TCNR, 0);
    check("pulse count", q, 32'h2);
    // Default routing: second pwm channel arms slot B
    wb(1, `TATC_ADR_TRG, 32'h0);
    wb(1, `TATC_ADR_SC1B, 32'h45);
    wb(1, `TATC_ADR_IMSK, 32'h2);
    po <= 1;
    repeat (6) @(posedge clk);
    po <= 0;
    wait_irq();
    wb(0, `TATC_ADR_RB, 0);
    check("pwm slot B", q, 32'h5545);
    summarize();
  end
endmodule : timed_adc_trigger_control_tb
`default_nettype wire

// >>> src/tatc_avg.sv
// Hardware averaging accumulator for converter samples
`default_nettype none
`include "tatc_defs.svh"
module tatc_avg (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clear_i,
  input  wire logic        valid_i,
  input  wire logic [15:0] sample_i,
  input  wire logic [2:0]  shift_i,
  output logic             done_o,
  output logic [15:0]      avg_o
);
  logic [20:0] acc_reg;
  logic [5:0]  cnt_reg;
  logic [20:0] sum;
  logic [5:0]  cnt_next;
  logic        last;
  assign sum      = acc_reg + {5'h00, sample_i};
  assign cnt_next = cnt_reg + 6'h01;
  assign last     = cnt_next == (6'h01 << shift_i);
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_reg <= 21'h000000;
      cnt_reg <= 6'h00;
      done_o  <= 1'b0;
      avg_o   <= 16'h0000;
    end else if (clear_i) begin
      acc_reg <= 21'h000000;
      cnt_reg <= 6'h00;
      done_o  <= 1'b0;
    end else begin
      done_o <= valid_i & last;
      if (valid_i && last) begin
        avg_o   <= 16'(sum >> shift_i);
        acc_reg <= 21'h000000;
        cnt_reg <= 6'h00;
      end else if (valid_i) begin
        acc_reg <= sum;
        cnt_reg <= cnt_next;
      end
    end
  end
  avg_count_bound_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cnt_reg < (6'h01 << shift_i)) else $error("average sample count overran its set size");
endmodule : tatc_avg
`default_nettype wire

// >>> src/tatc_timer.sv
// Low-power timer: clock select, timer_field_a, compare and pulse counting
`default_nettype none
`include "tatc_defs.svh"
module tatc_timer (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  src_i,
  input  wire logic        en_i,
  input  wire logic        pulse_mode_i,
  input  wire logic        free_i,
  input  wire logic [1:0]  pin_i,
  input  wire logic [1:0]  pcs_i,
  input  wire logic        byp_i,
  input  wire logic [3:0]  pre_i,
  input  wire logic [15:0] cmp_i,
  output logic [15:0]      count_o,
  output logic             hit_o
);
  logic [7:0]  s1_reg, s2_reg, s3_reg;
  logic [7:0]  rise;
  logic [16:0] pre_reg;
  logic [16:0] pre_lim;
  logic        raw, tick;
  // Every source is foreign to the core clock: two flops, then edge detect
  for (genvar i = 0; i < 8; i++) begin : g_sync
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        s1_reg[i] <= 1'b0;
        s2_reg[i] <= 1'b0;
        s3_reg[i] <= 1'b0;
      end else begin
        s1_reg[i] <= src_i[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
      end
    end
    assign rise[i] = s2_reg[i] & ~s3_reg[i];
  end
  assign raw     = pulse_mode_i ? rise[3'h4 + {1'b0, pin_i}] : rise[{1'b0, pcs_i}];
  assign pre_lim = 17'h1FFFF >> (5'h10 - {1'b0, pre_i});
  assign tick    = raw & (byp_i | (pre_reg == pre_lim));
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_reg <= 17'h00000;
    end else if (!en_i || byp_i) begin
      pre_reg <= 17'h00000;
    end else if (raw) begin
      pre_reg <= (pre_reg == pre_lim) ? 17'h00000 : pre_reg + 17'h00001;
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= 16'h0000;
      hit_o   <= 1'b0;
    end else begin
      hit_o <= en_i & tick & (count_o == cmp_i);
      if (!en_i) begin
        count_o <= 16'h0000;
      end else if (tick) begin
        count_o <= (count_o == cmp_i && !free_i) ? 16'h0000 : count_o + 16'h0001;
      end
    end
  end
  compare_reset_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    en_i && tick && count_o == cmp_i && !free_i |=> count_o == 16'h0000 && hit_o)
    else $error("timer did not clear and fire on compare match");
  timer_field_a_range_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pre_reg <= pre_lim || $changed(pre_i)) else $error("timer_field_a counter beyond division");
endmodule : tatc_timer
`default_nettype wire

// >>> src/tatc_top.sv
// Timed converter trigger control: bus registers, slot sequencing, pin routing
`default_nettype none
`include "tatc_defs.svh"
// Functional notes
// - A clear pin-bank select routes the first pin of a shared input, a set one the second.
// - Only input channels four to seven have the second pin; all others ignore the bank select.
// - The all-ones channel code selects nothing and starts no conversion except a calibration on slot A.
// - Reading a result register clears that slot's completion flag and its interrupt.
// - After reset the routing sends pwm channel zero to slot A and channel one to slot B, but only once hardware triggering is switched on.
// - The timer runs from the reference, 1kHz, 32kHz or external oscillator clock.
// - Timer_field_a code zero divides the timer clock by two, and the bypass skips division.
// - Without free running, the timer counter returns to zero on compare match.
// - Setting the timer enable bit starts the counter.
// - Calibration rewrites converter settings, which software must restore afterwards.
// - In pulse mode the timer counts one of three alternate pins or the comparator output.
// - The timer fires the converter trigger when its counter equals the compare value.
// - With averaging on, 4, 8, 16 or 32 samples are averaged before completion.
module tatc_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        pwm_timer_channel_zero_i,
  input  wire logic        pwm_timer_channel_one_i,
  input  wire logic        irc_clk_i,
  input  wire logic        lpo_clk_i,
  input  wire logic        rtc_clk_i,
  input  wire logic        osc_clk_i,
  input  wire logic        comparator_output_i,
  input  wire logic        pulse_input_alt_one_i,
  input  wire logic        pulse_input_alt_two_i,
  input  wire logic        pulse_input_alt_three_i,
  output logic             conv_start_o,
  output logic [4:0]       conv_channel_o,
  output logic             conv_bank_b_o,
  input  wire logic        conv_done_i,
  input  wire logic [15:0] conv_result_i
);
  import tatc_pkg::*;

  // ----------------------------------------
  // Registers and nets
  // ----------------------------------------
  logic [4:0]  ch_a_reg, ch_b_reg;
  logic        aien_a_reg, aien_b_reg, conversion_complete_flag_a_reg, conversion_complete_flag_b_reg;
  logic        bank_reg, hwtrg_reg, cal_reg, hardware_average_enable_reg, alt_reg, pre_reg;
  logic [1:0]  avgs_reg;
  logic        t_en_reg, t_mode_reg, t_free_reg, t_flag_reg, t_byp_reg;
  logic [1:0]  t_pin_reg, t_pcs_reg;
  logic [3:0]  t_pre_reg;
  logic [15:0] t_cmp_reg, res_a_reg, res_b_reg;
  logic [3:0]  stat_reg, mask_reg, stat_set;
  logic        pend_a_reg, pend_b_reg, slot_reg, cal_act_reg;
  logic [1:0]  pwm_s1_reg, pwm_s2_reg, pwm_s3_reg, pwm_rise;
  tatc_conv_state_type state_reg;
  logic        wb_hit, wr_en, rd_en;
  logic [7:0]  wb_off;
  logic [31:0] rd_data;
  logic        wr_sc1a, wr_sc1b, rd_ra, rd_rb;
  logic        set_a, set_b, clr_a, clr_b, launch_a, launch_b, launch_c;
  logic        avg_done, avg_clear, fin_a, fin_b, cal_fin;
  logic [15:0] avg_val, t_count;
  logic        t_hit;
  logic [2:0]  avg_shift;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign wb_off  = {wb_adr_i[7:2], 2'b00};
  assign wb_hit  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en   = wb_hit & wb_we_i & wb_sel_i[0];
  assign rd_en   = wb_hit & ~wb_we_i;
  assign wr_sc1a = wr_en && wb_off == `TATC_ADR_SC1A;
  assign wr_sc1b = wr_en && wb_off == `TATC_ADR_SC1B;
  assign rd_ra   = rd_en && wb_off == `TATC_ADR_RA;
  assign rd_rb   = rd_en && wb_off == `TATC_ADR_RB;

  always_comb begin
    rd_data = 32'h00000000;
    case (wb_off)
      `TATC_ADR_SC1A: rd_data[7:0] = {conversion_complete_flag_a_reg, aien_a_reg, 1'b0, ch_a_reg};
      `TATC_ADR_SC1B: rd_data[7:0] = {conversion_complete_flag_b_reg, aien_b_reg, 1'b0, ch_b_reg};
      `TATC_ADR_CFG2: rd_data[`TATC_CFG2_BANK] = bank_reg;
      `TATC_ADR_RA:   rd_data[15:0] = res_a_reg;
      `TATC_ADR_RB:   rd_data[15:0] = res_b_reg;
      `TATC_ADR_SC2:  rd_data[`TATC_SC2_HWTRG] = hwtrg_reg;
      `TATC_ADR_SC3:  rd_data[7:0] = {cal_reg, 4'h0, hardware_average_enable_reg, avgs_reg};
      `TATC_ADR_TRG:  rd_data[1:0] = {pre_reg, alt_reg};
      `TATC_ADR_TCSR: rd_data[7:0] = {t_flag_reg, 1'b0, t_pin_reg, 1'b0, t_free_reg, t_mode_reg, t_en_reg};
      `TATC_ADR_TPSR: rd_data[6:0] = {t_pre_reg, t_byp_reg, t_pcs_reg};
      `TATC_ADR_TCMR: rd_data[15:0] = t_cmp_reg;
      `TATC_ADR_TCNR: rd_data[15:0] = t_count;
      `TATC_ADR_IST:  rd_data[3:0] = stat_reg;
      `TATC_ADR_IMSK: rd_data[3:0] = mask_reg;
      default:        rd_data = 32'h00000000;
    endcase
  end

  // Every access, mapped or not, gets one ack cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch_a_reg   <= `TATC_CH_OFF;
      ch_b_reg   <= `TATC_CH_OFF;
      aien_a_reg <= 1'b0;
      aien_b_reg <= 1'b0;
      bank_reg   <= 1'b0;
      hwtrg_reg  <= 1'b0;
      hardware_average_enable_reg   <= 1'b0;
      avgs_reg   <= 2'h0;
      alt_reg    <= 1'b0;
      pre_reg    <= 1'b0;
      t_en_reg   <= 1'b0;
      t_mode_reg <= 1'b0;
      t_free_reg <= 1'b0;
      t_pin_reg  <= 2'h0;
      t_pcs_reg  <= 2'h0;
      t_byp_reg  <= 1'b0;
      t_pre_reg  <= 4'h0;
      t_cmp_reg  <= `TATC_CMR_RST;
      mask_reg   <= 4'h0;
    end else begin
      if (wr_sc1a) begin
        ch_a_reg   <= wb_dat_i[4:0];
        aien_a_reg <= wb_dat_i[`TATC_SC1_AIEN];
      end
      if (wr_sc1b) begin
        ch_b_reg   <= wb_dat_i[4:0];
        aien_b_reg <= wb_dat_i[`TATC_SC1_AIEN];
      end
      if (wr_en && wb_off == `TATC_ADR_CFG2) begin
        bank_reg <= wb_dat_i[`TATC_CFG2_BANK];
      end
      if (wr_en && wb_off == `TATC_ADR_SC2) begin
        hwtrg_reg <= wb_dat_i[`TATC_SC2_HWTRG];
      end
      if (cal_fin) begin
        hardware_average_enable_reg <= 1'b1;
        avgs_reg <= `TATC_CAL_AVGS;
      end else if (wr_en && wb_off == `TATC_ADR_SC3) begin
        hardware_average_enable_reg <= wb_dat_i[`TATC_SC3_HARDWARE_AVERAGE_ENABLE];
        avgs_reg <= wb_dat_i[1:0];
      end
      if (wr_en && wb_off == `TATC_ADR_TRG) begin
        alt_reg <= wb_dat_i[`TATC_TRG_ALT];
        pre_reg <= wb_dat_i[`TATC_TRG_PRE];
      end
      if (wr_en && wb_off == `TATC_ADR_TCSR) begin
        t_en_reg   <= wb_dat_i[`TATC_TCSR_EN];
        t_mode_reg <= wb_dat_i[`TATC_TCSR_MODE];
        t_free_reg <= wb_dat_i[`TATC_TCSR_FREE];
        t_pin_reg  <= wb_dat_i[`TATC_TCSR_PIN +: 2];
      end
      if (wr_en && wb_off == `TATC_ADR_TPSR) begin
        t_pcs_reg <= wb_dat_i[1:0];
        t_byp_reg <= wb_dat_i[`TATC_TPSR_BYP];
        t_pre_reg <= wb_dat_i[`TATC_TPSR_PRE +: 4];
      end
      if (wr_en && wb_off == `TATC_ADR_TCMR) begin
        t_cmp_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_hit && wb_we_i && wb_sel_i[1] && wb_off == `TATC_ADR_TCMR) begin
        t_cmp_reg[15:8] <= wb_dat_i[15:8];
      end
      if (wr_en && wb_off == `TATC_ADR_IMSK) begin
        mask_reg <= wb_dat_i[3:0];
      end
    end
  end

  // ----------------------------------------
  // Trigger routing
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_s1_reg <= 2'h0;
      pwm_s2_reg <= 2'h0;
      pwm_s3_reg <= 2'h0;
    end else begin
      pwm_s1_reg <= {pwm_timer_channel_one_i, pwm_timer_channel_zero_i};
      pwm_s2_reg <= pwm_s1_reg;
      pwm_s3_reg <= pwm_s2_reg;
    end
  end
  assign pwm_rise = pwm_s2_reg & ~pwm_s3_reg;

  // Hardware mode takes pwm edges unless the timer trigger is chosen
  assign set_a = hwtrg_reg ? (ch_a_reg != `TATC_CH_OFF) & (alt_reg ? t_hit & ~pre_reg : pwm_rise[0])
                           : wr_sc1a & (wb_dat_i[4:0] != `TATC_CH_OFF);
  assign set_b = hwtrg_reg & (ch_b_reg != `TATC_CH_OFF) & (alt_reg ? t_hit & pre_reg : pwm_rise[1]);
  assign clr_a = launch_a | (wr_sc1a & (wb_dat_i[4:0] == `TATC_CH_OFF));
  assign clr_b = launch_b | (wr_sc1b & (wb_dat_i[4:0] == `TATC_CH_OFF));

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_a_reg <= 1'b0;
      pend_b_reg <= 1'b0;
    end else begin
      pend_a_reg <= set_a | (pend_a_reg & ~clr_a);
      pend_b_reg <= set_b | (pend_b_reg & ~clr_b);
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  assign launch_c  = state_reg == CS_IDLE && cal_reg;
  assign launch_a  = state_reg == CS_IDLE && !cal_reg && pend_a_reg && ch_a_reg != `TATC_CH_OFF;
  assign launch_b  = state_reg == CS_IDLE && !cal_reg && !pend_a_reg && pend_b_reg
                     && ch_b_reg != `TATC_CH_OFF;
  assign avg_clear = launch_a | launch_b | launch_c;
  assign avg_shift = cal_act_reg ? `TATC_CAL_SHIFT : (hardware_average_enable_reg ? `TATC_AVG_BASE + {1'b0, avgs_reg} : 3'h0);
  assign fin_a     = state_reg == CS_WAIT && avg_done && !slot_reg;
  assign fin_b     = state_reg == CS_WAIT && avg_done && slot_reg;
  assign cal_fin   = fin_a && cal_act_reg;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg      <= CS_IDLE;
      slot_reg       <= 1'b0;
      cal_act_reg    <= 1'b0;
      conv_start_o   <= 1'b0;
      conv_channel_o <= `TATC_CH_OFF;
      conv_bank_b_o  <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      unique case (state_reg)
        CS_IDLE: begin
          if (avg_clear) begin
            slot_reg       <= launch_b;
            cal_act_reg    <= launch_c;
            conv_start_o   <= 1'b1;
            conv_channel_o <= launch_b ? ch_b_reg : ch_a_reg;
            conv_bank_b_o  <= bank_reg && (launch_b ? ch_b_reg : ch_a_reg) >= `TATC_BANK_LO
                              && (launch_b ? ch_b_reg : ch_a_reg) <= `TATC_BANK_HI;
            state_reg      <= CS_RUN;
          end
        end
        CS_RUN: begin
          if (conv_done_i) begin
            state_reg <= CS_WAIT;
          end
        end
        CS_WAIT: begin
          if (avg_done) begin
            cal_act_reg <= 1'b0;
            state_reg   <= CS_IDLE;
          end else begin
            conv_start_o <= 1'b1;
            state_reg    <= CS_RUN;
          end
        end
      endcase
    end
  end

  tatc_avg u_avg (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clear_i    (avg_clear),
    .valid_i    (state_reg == CS_RUN && conv_done_i),
    .sample_i   (conv_result_i),
    .shift_i    (avg_shift),
    .done_o     (avg_done),
    .avg_o      (avg_val)
  );

  tatc_timer u_timer (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .src_i        ({pulse_input_alt_three_i, pulse_input_alt_two_i, pulse_input_alt_one_i, comparator_output_i,
                    osc_clk_i, rtc_clk_i, lpo_clk_i, irc_clk_i}),
    .en_i         (t_en_reg),
    .pulse_mode_i (t_mode_reg),
    .free_i       (t_free_reg),
    .pin_i        (t_pin_reg),
    .pcs_i        (t_pcs_reg),
    .byp_i        (t_byp_reg),
    .pre_i        (t_pre_reg),
    .cmp_i        (t_cmp_reg),
    .count_o      (t_count),
    .hit_o        (t_hit)
  );

  // ----------------------------------------
  // Results, flags and interrupt
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_a_reg  <= 16'h0000;
      res_b_reg  <= 16'h0000;
      conversion_complete_flag_a_reg <= 1'b0;
      conversion_complete_flag_b_reg <= 1'b0;
      cal_reg    <= 1'b0;
      t_flag_reg <= 1'b0;
    end else begin
      if (fin_a) begin
        res_a_reg <= avg_val;
      end
      if (fin_b) begin
        res_b_reg <= avg_val;
      end
      // A finishing conversion wins over a clearing read or write
      conversion_complete_flag_a_reg <= fin_a | (conversion_complete_flag_a_reg & ~rd_ra & ~wr_sc1a);
      conversion_complete_flag_b_reg <= fin_b | (conversion_complete_flag_b_reg & ~rd_rb & ~wr_sc1b);
      cal_reg    <= (wr_en && wb_off == `TATC_ADR_SC3) ? wb_dat_i[`TATC_SC3_CAL] : cal_reg & ~cal_fin;
      t_flag_reg <= t_hit | (t_flag_reg & ~(wr_en && wb_off == `TATC_ADR_TCSR && wb_dat_i[`TATC_TCSR_FLAG]));
    end
  end

  assign stat_set = {cal_fin, t_hit, fin_b & aien_b_reg, fin_a & aien_a_reg};
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_reg <= 4'h0;
      irq_o    <= 1'b0;
    end else begin
      stat_reg <= stat_set | (stat_reg & ~((wr_en && wb_off == `TATC_ADR_IST) ? wb_dat_i[3:0] : 4'h0)
                  & ~{2'b00, rd_rb, rd_ra});
      irq_o    <= |(stat_reg & mask_reg);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence read_result_a_s;
    rd_ra && !fin_a;
  endsequence
  ack_single_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("bus ack held longer than one cycle");
  no_start_disabled_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    conv_start_o && !cal_act_reg |-> conv_channel_o != `TATC_CH_OFF) else $error("start on disabled code");
  bank_route_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    conv_bank_b_o |-> conv_channel_o >= `TATC_BANK_LO && conv_channel_o <= `TATC_BANK_HI)
    else $error("second pin chosen for a single-pin channel");
  read_clears_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    read_result_a_s |=> !conversion_complete_flag_a_reg) else $error("result read left completion flag set");
  done_sets_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    fin_a && aien_a_reg |=> conversion_complete_flag_a_reg && stat_reg[`TATC_IRQ_A]) else $error("finish did not flag slot A");
  pwm_pingpong_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    hwtrg_reg && !alt_reg && pwm_rise[1] && ch_b_reg != `TATC_CH_OFF |=> pend_b_reg)
    else $error("second pwm channel did not arm slot B");
  irq_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    |(stat_reg & mask_reg) |=> irq_o) else $error("unmasked status without interrupt");
  cal_rewrite_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cal_fin |=> hardware_average_enable_reg && avgs_reg == `TATC_CAL_AVGS && !cal_reg) else $error("calibration left config");
endmodule : tatc_top
`default_nettype wire
